//--- pkg/clock_status_monitor_consts.svh
`ifndef CLOCK_STATUS_MONITOR_CONSTS_SVH
`define CLOCK_STATUS_MONITOR_CONSTS_SVH

// Byte addresses of the status register and of the interrupt control word.
`define CSM_STATUS_ADDR      32'h4002_8018
`define CSM_IRQ_CTRL_ADDR    32'h4002_801C

// Reset values.
`define CSM_STATUS_RESET     16'h0003
`define CSM_IRQ_CTRL_RESET   1'b1
`define CSM_SYNC_RESET       2'h1

// Field positions inside the status register.
`define CSM_BIT_RSVD_TOP     15
`define CSM_BIT_XTAL_UNSTBL  14
`define CSM_BIT_XTAL_STBL    13
`define CSM_BIT_XTAL_NOW     12
`define CSM_BIT_PLL_LOST     2
`define CSM_BIT_PLL_GAINED   1
`define CSM_BIT_PLL_NOW      0

// Field position inside the interrupt control word.
`define CSM_BIT_IRQ_EN       0

// Indicator positions on the synchroniser.
`define CSM_IDX_PLL          0
`define CSM_IDX_XTAL         1

// AXI response codes.
`define CSM_RESP_OKAY        2'h0
`define CSM_RESP_SLVERR      2'h2

`endif

//--- pkg/clock_status_monitor_pkg.sv
package clock_status_monitor_pkg;

  // State of the two-stage indicator synchroniser.
  typedef struct packed {
    logic [1:0] meta;
    logic [1:0] level;
  } level_sync_s;

  // Whole state of the status monitor and its bus slave.
  typedef struct packed {
    logic        pll_prev;
    logic        xtal_prev;
    logic        xtal_unstable_flag;
    logic        xtal_stable_flag;
    logic        pll_lock_lost_flag;
    logic        pll_lock_gained_flag;
    logic        irq_enable;
    logic        irq;
    logic        aw_have;
    logic        w_have;
    logic [31:0] awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } monitor_state_s;

endpackage

//--- rtl/level_sync.sv
`timescale 1ns/10ps
`include "clock_status_monitor_consts.svh"

module level_sync (
  // Clock and reset.
  input  wire logic       clk_in,
  input  wire logic       rstn_in,
  // Asynchronous levels and their synchronised copies.
  input  wire logic [1:0] async_in,
  output logic      [1:0] level_out
);
  import clock_status_monitor_pkg::*;

  level_sync_s s_q;
  level_sync_s s_d;

  // The first stage feeds only the second stage.
  always_comb begin
    s_d       = s_q;
    s_d.meta  = async_in;
    s_d.level = s_q.meta;
  end

  // Both stages reset to the indicator levels the register reports at reset.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_q <= {`CSM_SYNC_RESET, `CSM_SYNC_RESET};
    end else begin
      s_q <= s_d;
    end
  end

  assign level_out = s_q.level;

endmodule // level_sync

//--- rtl/clock_status_monitor.sv
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/10ps
`include "clock_status_monitor_consts.svh"

module clock_status_monitor (
  // Clock and reset.
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  // Analogue indicators.
  input  wire logic        pll_lock_in,
  input  wire logic        xtal_stable_in,
  // AXI4-Lite write address channel.
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [31:0] s_axi_awaddr_in,
  input  wire logic [2:0]  s_axi_awprot_in,
  // AXI4-Lite write data channel.
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  // AXI4-Lite write response channel.
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  output logic      [1:0]  s_axi_bresp_out,
  // AXI4-Lite read address channel.
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  input  wire logic [31:0] s_axi_araddr_in,
  input  wire logic [2:0]  s_axi_arprot_in,
  // AXI4-Lite read data channel.
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  output logic      [31:0] s_axi_rdata_out,
  output logic      [1:0]  s_axi_rresp_out,
  // Interrupt request toward the core.
  output logic             irq_out
);
  import clock_status_monitor_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // True when a written bit is one and its byte lane is enabled.
  function automatic logic wr_one(input logic [31:0] data,
                                  input logic [3:0]  strb,
                                  input int          pos);
    logic [4:0] p;
    p      = pos[4:0];
    wr_one = data[p] & strb[p[4:3]];
  endfunction

  // Status word as software sees it.
  function automatic logic [31:0] status_word(input monitor_state_s s,
                                              input logic pll_now,
                                              input logic xtal_now);
    logic [31:0] w;
    w                       = 32'h0000_0000;
    w[`CSM_BIT_RSVD_TOP]    = 1'b0;
    w[`CSM_BIT_XTAL_UNSTBL] = s.xtal_unstable_flag;
    w[`CSM_BIT_XTAL_STBL]   = s.xtal_stable_flag;
    w[`CSM_BIT_XTAL_NOW]    = xtal_now;
    w[`CSM_BIT_PLL_LOST]    = s.pll_lock_lost_flag;
    w[`CSM_BIT_PLL_GAINED]  = s.pll_lock_gained_flag;
    w[`CSM_BIT_PLL_NOW]     = pll_now;
    status_word             = w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Indicator synchronisation.

  logic [1:0] ind_level;
  logic       pll_now;
  logic       xtal_now;

  // Both indicators pass through two flip-flops before use.
  level_sync u_level_sync (
    .clk_in    (clk_in),
    .rstn_in   (rstn_in),
    .async_in  ({xtal_stable_in, pll_lock_in}),
    .level_out (ind_level)
  );

  assign pll_now  = ind_level[`CSM_IDX_PLL];
  assign xtal_now = ind_level[`CSM_IDX_XTAL];

  ////////////////////////////////////////////////////////////////////////////
  // State.

  // Named copy of the reset word, so that single bits can be picked from it.
  localparam logic [15:0] STATUS_RESET = `CSM_STATUS_RESET;

  localparam monitor_state_s RESET_STATE = '{
    pll_prev             : STATUS_RESET[`CSM_BIT_PLL_NOW],
    xtal_prev            : STATUS_RESET[`CSM_BIT_XTAL_NOW],
    xtal_unstable_flag   : STATUS_RESET[`CSM_BIT_XTAL_UNSTBL],
    xtal_stable_flag     : STATUS_RESET[`CSM_BIT_XTAL_STBL],
    pll_lock_lost_flag   : STATUS_RESET[`CSM_BIT_PLL_LOST],
    pll_lock_gained_flag : STATUS_RESET[`CSM_BIT_PLL_GAINED],
    irq_enable           : `CSM_IRQ_CTRL_RESET,
    irq                  : 1'b0,
    aw_have              : 1'b0,
    w_have               : 1'b0,
    awaddr               : 32'h0000_0000,
    wdata                : 32'h0000_0000,
    wstrb                : 4'h0,
    awready              : 1'b1,
    wready               : 1'b1,
    bvalid               : 1'b0,
    bresp                : `CSM_RESP_OKAY,
    arready              : 1'b1,
    rvalid               : 1'b0,
    rdata                : 32'h0000_0000,
    rresp                : `CSM_RESP_OKAY
  };

  monitor_state_s s_q;
  monitor_state_s s_d;

  logic pll_rise;
  logic pll_fall;
  logic xtal_rise;
  logic xtal_fall;
  logic wr_go;
  logic wr_status;
  logic wr_ctrl;
  logic clr_xnok;
  logic clr_xok;
  logic clr_lost;
  logic clr_gained;

  ////////////////////////////////////////////////////////////////////////////
  // Edge detection and write decode.

  // Edges come from the synchronised level against the last sample.
  assign pll_rise  = pll_now & ~s_q.pll_prev;
  assign pll_fall  = ~pll_now & s_q.pll_prev;
  assign xtal_rise = xtal_now & ~s_q.xtal_prev;
  assign xtal_fall = ~xtal_now & s_q.xtal_prev;

  // A write executes once address and data are both held.
  assign wr_go     = s_q.aw_have & s_q.w_have & ~s_q.bvalid;
  assign wr_status = wr_go & (s_q.awaddr == `CSM_STATUS_ADDR);
  assign wr_ctrl   = wr_go & (s_q.awaddr == `CSM_IRQ_CTRL_ADDR);

  // Clear strobes: only a written one clears, a zero leaves the flag.
  assign clr_xnok   = wr_status &
                      wr_one(s_q.wdata, s_q.wstrb, `CSM_BIT_XTAL_UNSTBL);
  assign clr_xok    = wr_status &
                      wr_one(s_q.wdata, s_q.wstrb, `CSM_BIT_XTAL_STBL);
  assign clr_lost   = wr_status &
                      wr_one(s_q.wdata, s_q.wstrb, `CSM_BIT_PLL_LOST);
  assign clr_gained = wr_status &
                      wr_one(s_q.wdata, s_q.wstrb, `CSM_BIT_PLL_GAINED);

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  always_comb begin
    s_d           = s_q;
    s_d.pll_prev  = pll_now;
    s_d.xtal_prev = xtal_now;

    // Sticky flags: an event in the clearing cycle still sets the flag.
    s_d.xtal_unstable_flag   = (s_q.xtal_unstable_flag & ~clr_xnok) |
                               xtal_fall;
    s_d.xtal_stable_flag     = (s_q.xtal_stable_flag & ~clr_xok) |
                               xtal_rise;
    s_d.pll_lock_lost_flag   = (s_q.pll_lock_lost_flag & ~clr_lost) |
                               pll_fall;
    s_d.pll_lock_gained_flag = (s_q.pll_lock_gained_flag & ~clr_gained) |
                               pll_rise;

    // Interrupt enable word.
    if (wr_ctrl && s_q.wstrb[0]) begin
      s_d.irq_enable = s_q.wdata[`CSM_BIT_IRQ_EN];
    end

    // Write address and data are taken in either order.
    if (s_axi_awvalid_in && s_q.awready) begin
      s_d.aw_have = 1'b1;
      s_d.awaddr  = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && s_q.wready) begin
      s_d.w_have = 1'b1;
      s_d.wdata  = s_axi_wdata_in;
      s_d.wstrb  = s_axi_wstrb_in;
    end

    // Write response: unmapped addresses answer with a slave error.
    if (s_q.bvalid && s_axi_bready_in) begin
      s_d.bvalid = 1'b0;
    end
    if (wr_go) begin
      s_d.aw_have = 1'b0;
      s_d.w_have  = 1'b0;
      s_d.bvalid  = 1'b1;
      if (wr_status || wr_ctrl) begin
        s_d.bresp = `CSM_RESP_OKAY;
      end else begin
        s_d.bresp = `CSM_RESP_SLVERR;
      end
    end
    s_d.awready = ~s_d.aw_have & ~s_d.bvalid;
    s_d.wready  = ~s_d.w_have & ~s_d.bvalid;

    // Read channel: one read at a time, data sampled at the address edge.
    if (s_q.rvalid && s_axi_rready_in) begin
      s_d.rvalid  = 1'b0;
      s_d.arready = 1'b1;
    end
    if (s_axi_arvalid_in && s_q.arready) begin
      s_d.arready = 1'b0;
      s_d.rvalid  = 1'b1;
      s_d.rresp   = `CSM_RESP_OKAY;
      if (s_axi_araddr_in == `CSM_STATUS_ADDR) begin
        s_d.rdata = status_word(s_q, pll_now, xtal_now);
      end else if (s_axi_araddr_in == `CSM_IRQ_CTRL_ADDR) begin
        s_d.rdata                  = 32'h0000_0000;
        s_d.rdata[`CSM_BIT_IRQ_EN] = s_q.irq_enable;
      end else begin
        s_d.rdata = 32'h0000_0000;
        s_d.rresp = `CSM_RESP_SLVERR;
      end
    end

    // Any set flag requests the core while interrupts are enabled.
    s_d.irq = s_d.irq_enable &
              (s_d.xtal_unstable_flag | s_d.xtal_stable_flag |
               s_d.pll_lock_lost_flag | s_d.pll_lock_gained_flag);
  end

  // State register.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_q <= RESET_STATE;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, each straight from the state register.

  assign s_axi_awready_out = s_q.awready;
  assign s_axi_wready_out  = s_q.wready;
  assign s_axi_bvalid_out  = s_q.bvalid;
  assign s_axi_bresp_out   = s_q.bresp;
  assign s_axi_arready_out = s_q.arready;
  assign s_axi_rvalid_out  = s_q.rvalid;
  assign s_axi_rdata_out   = s_q.rdata;
  assign s_axi_rresp_out   = s_q.rresp;
  assign irq_out           = s_q.irq;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rstn_in);

  logic rd_status;
  assign rd_status = s_axi_arvalid_in & s_q.arready &
                     (s_axi_araddr_in == `CSM_STATUS_ADDR);

  // Reserved top bit never reads as one.
  AST_RSVD_ZERO: assert property (
    rd_status |=> (s_axi_rvalid_out && !s_axi_rdata_out[`CSM_BIT_RSVD_TOP])
  ) else $error("Reserved status bit read as one.");

  // Crystal fall sets the unstable flag next cycle and it holds.
  AST_XTAL_FALL: assert property (
    xtal_fall ##1 !clr_xnok |-> s_q.xtal_unstable_flag ##1
      s_q.xtal_unstable_flag
  ) else $error("Crystal unstable flag not set on fall.");

  // Crystal rise sets the stable flag.
  AST_XTAL_RISE: assert property (
    $rose(xtal_now) |=> s_q.xtal_stable_flag
  ) else $error("Crystal stable flag not set on rise.");

  // A one written to the crystal stable flag clears it when no event competes.
  AST_XTAL_CLR: assert property (
    clr_xok && !xtal_rise |=> !s_q.xtal_stable_flag
  ) else $error("Crystal stable flag not cleared by write.");

  // A set crystal unstable flag raises the request while enabled.
  AST_IRQ: assert property (
    s_q.irq_enable && s_q.xtal_unstable_flag && !clr_xnok
      && !wr_ctrl |=> irq_out
  ) else $error("Interrupt missing for set crystal flag.");

  // Live crystal bit follows the synchronised level.
  AST_XTAL_NOW: assert property (
    rd_status |=> s_axi_rdata_out[`CSM_BIT_XTAL_NOW] == $past(xtal_now)
  ) else $error("Crystal status bit does not match level.");

  // Lock loss sets the lost flag.
  AST_PLL_FALL: assert property (
    $fell(pll_now) |=> s_q.pll_lock_lost_flag
  ) else $error("Lock lost flag not set on loss.");

  // A one written to the gained flag clears it when no event competes.
  AST_PLL_CLR: assert property (
    clr_gained && !pll_rise |=> !s_q.pll_lock_gained_flag
  ) else $error("Lock gained flag not cleared by write.");

  // Once clear, the lost flag stays clear without a new loss.
  AST_LOST_NO_REARM: assert property (
    !s_q.pll_lock_lost_flag && !pll_fall |=> !s_q.pll_lock_lost_flag
  ) else $error("Lock lost flag set without a loss.");

  // Once clear, the gained flag stays clear without a relock.
  AST_GAINED_NO_REARM: assert property (
    !s_q.pll_lock_gained_flag && !pll_rise |=> !s_q.pll_lock_gained_flag
  ) else $error("Lock gained flag set without a relock.");

  // Live lock bit follows the synchronised level, writes cannot change it.
  AST_PLL_NOW: assert property (
    rd_status |=> s_axi_rdata_out[`CSM_BIT_PLL_NOW] == $past(pll_now)
  ) else $error("Lock status bit does not match level.");

  // An event in the clearing cycle wins.
  AST_SET_WINS: assert property (
    clr_lost && pll_fall |=> s_q.pll_lock_lost_flag
  ) else $error("Lock loss dropped by a same cycle clear.");

  // A write of zero leaves a set flag alone.
  AST_ZERO_KEEPS: assert property (
    wr_status && s_q.pll_lock_gained_flag && !clr_gained
      |=> s_q.pll_lock_gained_flag
  ) else $error("Zero write cleared a flag.");

endmodule // clock_status_monitor

//--- testbench/pll_xtal_model.sv
`timescale 1ns/10ps

module pll_xtal_model (
  // Clock that paces the settling counters.
  input  wire logic       clk_in,
  // Requested states and settling time in cycles.
  input  wire logic       pll_want_in,
  input  wire logic       xtal_want_in,
  input  wire logic [7:0] settle_in,
  // Indicator levels seen by the monitor.
  output logic            pll_lock_out,
  output logic            xtal_stable_out
);
  logic [7:0] pll_cnt;
  logic [7:0] xtal_cnt;

  // Power up with the loop locked and the crystal not yet stable.
  initial begin
    pll_lock_out    = 1'b1;
    xtal_stable_out = 1'b0;
    pll_cnt         = 8'h00;
    xtal_cnt        = 8'h00;
  end

  // Each indicator follows its request only after the settling time.
  // Levels change just after a rising edge, like every other input.
  always @(posedge clk_in) begin
    if (pll_want_in == pll_lock_out) begin
      pll_cnt <= 8'h00;
    end else if (pll_cnt >= settle_in) begin
      pll_lock_out <= pll_want_in;
    end else begin
      pll_cnt <= pll_cnt + 8'h01;
    end
    if (xtal_want_in == xtal_stable_out) begin
      xtal_cnt <= 8'h00;
    end else if (xtal_cnt >= settle_in) begin
      xtal_stable_out <= xtal_want_in;
    end else begin
      xtal_cnt <= xtal_cnt + 8'h01;
    end
  end
endmodule // pll_xtal_model

//--- testbench/clock_status_monitor_tb.sv
`timescale 1ns/10ps
`include "clock_status_monitor_consts.svh"

`define CHK(nm, ex, ac) begin cmp_count++; if ((ac) !== (ex)) begin num_errors++; $display("ERROR %s expected %0h seen %0h", nm, ex, ac); end end

module clock_status_monitor_tb;
  logic        clk_in, rstn_in, pll_want, xtal_want, pll_lock, xtal_stable;
  logic [7:0]  settle;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, irq;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  int          num_errors, cmp_count, cycles;

  localparam logic [31:0] ST = `CSM_STATUS_ADDR;
  localparam logic [31:0] IC = `CSM_IRQ_CTRL_ADDR;

  pll_xtal_model model_u (.clk_in(clk_in), .pll_want_in(pll_want),
    .xtal_want_in(xtal_want), .settle_in(settle),
    .pll_lock_out(pll_lock), .xtal_stable_out(xtal_stable));

  clock_status_monitor dut_u (.clk_in(clk_in), .rstn_in(rstn_in),
    .pll_lock_in(pll_lock), .xtal_stable_in(xtal_stable),
    .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_awaddr_in(awaddr), .s_axi_awprot_in(3'h0),
    .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_bresp_out(bresp), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_araddr_in(araddr),
    .s_axi_arprot_in(3'h0), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .irq_out(irq));

  // Free-running 250 MHz clock.
  always #2 clk_in = ~clk_in;

  // Print the verdict and stop.
  task automatic end_of_test();
    if (num_errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Cut a hung run short.
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      end_of_test();
    end
  end

  // One full write; each channel is released when it is taken.
  task automatic wr(input logic [31:0] a, d, input logic [1:0] er);
    @(posedge clk_in);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clk_in);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    `CHK("bresp", er, bresp)
  endtask

  // One full read compared with the expected word and response.
  task automatic rd(input logic [31:0] a, ed, input logic [1:0] er);
    @(posedge clk_in);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clk_in);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    `CHK("rdata", ed, rdata)
    `CHK("rresp", er, rresp)
  endtask

  // Ask the analogue side for new levels and let them reach the flags.
  task automatic ind(input logic p, x, input logic [7:0] s);
    @(posedge clk_in);
    settle    <= s;
    pll_want  <= p;
    xtal_want <= x;
    repeat (int'(s) + 10) @(posedge clk_in);
  endtask

  // Let the registered request settle, then compare it.
  task automatic irq_chk(input logic e);
    repeat (2) @(posedge clk_in);
    `CHK("irq_out", e, irq)
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    clk_in = 1'b0;
    rstn_in = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, wdata, araddr} = {32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
    wstrb = 4'hF;
    settle = 8'h00;
    pll_want = 1'b1;
    xtal_want = 1'b0;
    num_errors = 0;
    cmp_count = 0;
    cycles = 0;
    repeat (6) @(posedge clk_in);
    rstn_in <= 1'b1;
    rd(ST, 32'h0000_0003, `CSM_RESP_OKAY);
    irq_chk(1'b1);
    // Writing ones everywhere clears flags but not live or reserved bits.
    wr(ST, 32'hFFFF_FFFF, `CSM_RESP_OKAY);
    rd(ST, 32'h0000_0001, `CSM_RESP_OKAY);
    irq_chk(1'b0);
    // Crystal becomes stable, then zero writes, then a one clears.
    ind(1'b1, 1'b1, 8'h00);
    rd(ST, 32'h0000_3001, `CSM_RESP_OKAY);
    irq_chk(1'b1);
    wr(ST, 32'h0000_0000, `CSM_RESP_OKAY);
    rd(ST, 32'h0000_3001, `CSM_RESP_OKAY);
    wr(ST, 32'h0000_2000, `CSM_RESP_OKAY);
    rd(ST, 32'h0000_1001, `CSM_RESP_OKAY);
    // Crystal drops out slowly.
    ind(1'b1, 1'b0, 8'h28);
    rd(ST, 32'h0000_4001, `CSM_RESP_OKAY);
    irq_chk(1'b1);
    wr(ST, 32'h0000_4000, `CSM_RESP_OKAY);
    rd(ST, 32'h0000_0001, `CSM_RESP_OKAY);
    // Lock lost, cleared, and no repeat while still unlocked.
    ind(1'b0, 1'b0, 8'h03);
    rd(ST, 32'h0000_0004, `CSM_RESP_OKAY);
    irq_chk(1'b1);
    wr(ST, 32'h0000_0005, `CSM_RESP_OKAY);
    repeat (20) @(posedge clk_in);
    rd(ST, 32'h0000_0000, `CSM_RESP_OKAY);
    irq_chk(1'b0);
    // Relock, clear, no repeat while locked, then a new loss and relock.
    ind(1'b1, 1'b0, 8'h00);
    rd(ST, 32'h0000_0003, `CSM_RESP_OKAY);
    wr(ST, 32'h0000_0002, `CSM_RESP_OKAY);
    repeat (20) @(posedge clk_in);
    rd(ST, 32'h0000_0001, `CSM_RESP_OKAY);
    ind(1'b0, 1'b0, 8'h00);
    ind(1'b1, 1'b0, 8'h00);
    rd(ST, 32'h0000_0007, `CSM_RESP_OKAY);
    wr(ST, 32'h0000_0006, `CSM_RESP_OKAY);
    rd(ST, 32'h0000_0001, `CSM_RESP_OKAY);
    // A loss that lands in the cycle of its own clearing write stays set.
    pll_want <= 1'b0;
    @(posedge clk_in);
    wr(ST, 32'h0000_0004, `CSM_RESP_OKAY);
    rd(ST, 32'h0000_0004, `CSM_RESP_OKAY);
    ind(1'b1, 1'b0, 8'h00);
    wr(ST, 32'h0000_0006, `CSM_RESP_OKAY);
    rd(ST, 32'h0000_0001, `CSM_RESP_OKAY);
    // Masked crystal event holds its flag but no request.
    rd(IC, 32'h0000_0001, `CSM_RESP_OKAY);
    wr(IC, 32'h0000_0000, `CSM_RESP_OKAY);
    ind(1'b1, 1'b1, 8'h05);
    rd(ST, 32'h0000_3001, `CSM_RESP_OKAY);
    irq_chk(1'b0);
    wr(IC, 32'h0000_0001, `CSM_RESP_OKAY);
    irq_chk(1'b1);
    wr(ST, 32'h0000_2000, `CSM_RESP_OKAY);
    irq_chk(1'b0);
    // Unmapped place is refused without effect.
    rd(ST + 32'h0000_0008, 32'h0000_0000, `CSM_RESP_SLVERR);
    wr(ST + 32'h0000_0008, 32'hFFFF_FFFF, `CSM_RESP_SLVERR);
    rd(ST, 32'h0000_1001, `CSM_RESP_OKAY);
    end_of_test();
  end
endmodule // clock_status_monitor_tb
